// File: src/tmrtb_timebase.sv
// Purpose: 16-bit prescaled timebase with wrap limit, flag and APB registers
// Assumes: 250 MHz pclk as bus clock; break and stop mode come from system logic
// Notes: Register bytes sit in bits 7:0; upper bits read zero
`timescale 1ns/1ps
`default_nettype none
module tmrtb_timebase #(
   parameter bit HAS_EXT_CLOCK = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic break_active,
   input wire logic stop_mode,
   input wire logic external_count_clock,
   output logic wrap_irq,
   output logic [15:0] count_value,
   output logic wrap_event
);
   // ****************************************
   // Storage
   // ****************************************
   localparam int PRESCALE_W = tmrtb_pkg::PRESCALE_WIDTH;
   logic [15:0] count;
   logic [15:0] limit;
   logic [7:0] limit_high_buf;
   logic [PRESCALE_W-1:0] prescale;
   logic [2:0] clock_divider_select;
   logic wrap_flag;
   logic wrap_irq_enable;
   logic counter_halt;
   logic break_clear_enable;
   logic flag_read_armed;
   logic limit_inhibit;
   logic low_latched;
   logic [7:0] low_latch;
   logic ext_sync1;
   logic ext_sync2;
   logic ext_prev;

   // ****************************************
   // Bus decode
   // ****************************************
   logic setup_phase;
   logic access;
   logic wr;
   logic rd;
   logic rd_setup;
   logic sel_sc;
   logic sel_ch;
   logic sel_cl;
   logic sel_lh;
   logic sel_ll;
   logic sel_bc;
   logic mapped;
   logic [7:0] wbyte;
   logic wr_sc;
   logic wr_bc;
   logic wr_lh;
   logic wr_ll;
   logic rd_cl;
   logic take_ch;
   logic status_ok;
   logic counter_reset;
   assign setup_phase = psel && !penable;
   assign access = psel && penable && pready;
   assign wr = access && pwrite && pstrb[0];
   assign rd = access && !pwrite;
   assign rd_setup = setup_phase && !pwrite;
   assign sel_sc = (paddr == tmrtb_pkg::ADDR_STATUS_CONTROL);
   assign sel_ch = (paddr == tmrtb_pkg::ADDR_COUNT_HIGH);
   assign sel_cl = (paddr == tmrtb_pkg::ADDR_COUNT_LOW);
   assign sel_lh = (paddr == tmrtb_pkg::ADDR_LIMIT_HIGH);
   assign sel_ll = (paddr == tmrtb_pkg::ADDR_LIMIT_LOW);
   assign sel_bc = (paddr == tmrtb_pkg::ADDR_BREAK_CONTROL);
   assign mapped = sel_sc | sel_ch | sel_cl | sel_lh | sel_ll | sel_bc;
   assign wbyte = pwdata[7:0];
   assign wr_sc = wr && sel_sc;
   assign wr_bc = wr && sel_bc;
   assign wr_lh = wr && sel_lh;
   assign wr_ll = wr && sel_ll;
   assign rd_cl = rd && sel_cl;
   // Latch at setup, so both bytes agree
   assign take_ch = rd_setup && sel_ch && !low_latched;
   // Status side effects gated in break
   assign status_ok = !break_active || break_clear_enable;
   assign counter_reset = wr_sc && wbyte[tmrtb_pkg::BIT_COUNTER_RESET];

   // ****************************************
   // Timer clock selection
   // ****************************************
   logic [PRESCALE_W:0] tap_mask;
   logic [PRESCALE_W-1:0] tap_bits;
   logic div_tick;
   logic use_ext;
   logic ext_tick;
   logic running;
   logic tick;
   assign tap_mask =
      (PRESCALE_W+1)'((7'h01 << clock_divider_select) - 7'h01);
   assign tap_bits = tap_mask[PRESCALE_W-1:0];
   assign div_tick = ((prescale & tap_bits) == tap_bits);
   // External edge only when HAS_EXT_CLOCK is set
   assign use_ext = HAS_EXT_CLOCK &&
      (clock_divider_select == tmrtb_pkg::DIV_SELECT_EXTERNAL);
   assign ext_tick = ext_sync2 && !ext_prev;
   assign running = !counter_halt && !break_active && !stop_mode;
   assign tick = running && (use_ext ? ext_tick : div_tick);

   // ****************************************
   // Wrap and clear decisions
   // ****************************************
   logic at_limit;
   logic wrap;
   logic wrap_set;
   logic flag_clear;
   logic arm_read;
   logic next_wrap_flag;
   logic next_armed;
   logic [15:0] next_count;
   assign at_limit = (count == limit);
   assign wrap = tick && at_limit && !counter_reset;
   // Flag held off during limit update
   assign wrap_set = wrap && !limit_inhibit;
   // Zero write clears only when armed
   assign flag_clear = wr_sc && !wbyte[tmrtb_pkg::BIT_WRAP_FLAG] &&
      flag_read_armed && status_ok;
   // Break reads arm only with break clear enable; arm on the value returned
   assign arm_read = rd_setup && sel_sc && wrap_flag && status_ok;
   assign next_wrap_flag = wrap_set || (wrap_flag && !flag_clear);
   assign next_armed = !wrap_set && !flag_clear &&
      (flag_read_armed || arm_read);
   // Step by one per timer clock
   assign next_count = at_limit ? tmrtb_pkg::RESET_COUNT :
      count + 16'h0001;

   // ****************************************
   // Read selection
   // ****************************************
   logic [7:0] status_byte;
   logic [7:0] low_view;
   logic [7:0] rbyte;
   assign status_byte = {wrap_flag, wrap_irq_enable, counter_halt, 2'b00,
      clock_divider_select};
   assign low_view = low_latched ? low_latch : count[7:0];
   assign rbyte = sel_sc ? status_byte :
      sel_ch ? count[15:8] :
      sel_cl ? low_view :
      sel_lh ? limit[15:8] :
      sel_ll ? limit[7:0] :
      sel_bc ? {7'h00, break_clear_enable} : 8'h00;

   // ****************************************
   // APB answer, no wait states
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= setup_phase;
         pslverr <= setup_phase && !mapped;
      end
   end
   // Data zero outside reads, so stale bytes never leak
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         prdata <= rd_setup ? {24'h000000, rbyte} : 32'h00000000;
      end
   end

   // ****************************************
   // External clock synchroniser
   // ****************************************
   // Edge detect needs slow external clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev <= 1'b0;
      end else if (clk_en) begin
         ext_sync1 <= external_count_clock;
         ext_sync2 <= ext_sync1;
         ext_prev <= ext_sync2;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_divider_select <= tmrtb_pkg::RESET_DIV_SELECT;
         wrap_irq_enable <= 1'b0;
         counter_halt <= tmrtb_pkg::RESET_HALT;
      end else if (clk_en) begin
         if (wr_sc) begin
            clock_divider_select <= wbyte[2:0];
            wrap_irq_enable <= wbyte[tmrtb_pkg::BIT_WRAP_IRQ_ENABLE];
            counter_halt <= wbyte[tmrtb_pkg::BIT_COUNTER_HALT];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_clear_enable <= 1'b0;
      end else if (clk_en) begin
         if (wr_bc) begin
            break_clear_enable <= wbyte[tmrtb_pkg::BIT_BREAK_CLEAR_ENABLE];
         end
      end
   end

   // ****************************************
   // Wrap flag and clear sequence
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_flag <= 1'b0;
      end else if (clk_en) begin
         wrap_flag <= next_wrap_flag;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_read_armed <= 1'b0;
      end else if (clk_en) begin
         flag_read_armed <= next_armed;
      end
   end

   // ****************************************
   // Counter and prescaler
   // ****************************************
   // Reset bit clears counter bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= tmrtb_pkg::RESET_COUNT;
      end else if (clk_en) begin
         if (counter_reset) begin
            count <= tmrtb_pkg::RESET_COUNT;
         end else if (tick) begin
            count <= next_count;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= '0;
      end else if (clk_en) begin
         if (counter_reset) begin
            prescale <= '0;
         end else if (running) begin
            prescale <= prescale + 1'b1;
         end
      end
   end

   // ****************************************
   // Limit registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit <= tmrtb_pkg::RESET_LIMIT;
         limit_high_buf <= 8'hFF;
         limit_inhibit <= 1'b0;
      end else if (clk_en) begin
         // High byte buffered until low write
         if (wr_lh) begin
            limit_high_buf <= wbyte;
            limit_inhibit <= 1'b1;
         end else if (wr_ll) begin
            limit <= {limit_high_buf, wbyte};
            limit_inhibit <= 1'b0;
         end
      end
   end

   // ****************************************
   // Low-byte latch
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_latched <= 1'b0;
         low_latch <= 8'h00;
      end else if (clk_en) begin
         // Latch held until low byte read
         if (rd_cl) begin
            low_latched <= 1'b0;
         end else if (take_ch) begin
            low_latched <= 1'b1;
            low_latch <= count[7:0];
         end else if (counter_reset) begin
            low_latch <= 8'h00;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Request follows flag and enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_irq <= 1'b0;
      end else if (clk_en) begin
         wrap_irq <= next_wrap_flag && wrap_irq_enable;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_event <= 1'b0;
      end else if (clk_en) begin
         wrap_event <= wrap_set;
      end
   end
   // Copy lags one cycle; keeps the output a plain flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= tmrtb_pkg::RESET_COUNT;
      end else if (clk_en) begin
         count_value <= count;
      end
   end
endmodule
`default_nettype wire

// File: src/tmrtb_pkg.sv
// Purpose: Constants for the timer timebase block
// Assumes: APB slave, byte registers in the low bits of aligned words
// Notes: Offsets are local choices
package tmrtb_pkg;
   localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_COUNT_HIGH = 12'h004;
   localparam logic [11:0] ADDR_COUNT_LOW = 12'h008;
   localparam logic [11:0] ADDR_LIMIT_HIGH = 12'h00C;
   localparam logic [11:0] ADDR_LIMIT_LOW = 12'h010;
   localparam logic [11:0] ADDR_BREAK_CONTROL = 12'h014;
   localparam int BIT_WRAP_FLAG = 7;
   localparam int BIT_WRAP_IRQ_ENABLE = 6;
   localparam int BIT_COUNTER_HALT = 5;
   localparam int BIT_COUNTER_RESET = 4;
   localparam int BIT_BREAK_CLEAR_ENABLE = 0;
   localparam logic [2:0] DIV_SELECT_EXTERNAL = 3'h7;
   localparam logic [2:0] RESET_DIV_SELECT = 3'h0;
   localparam logic [15:0] RESET_LIMIT = 16'hFFFF;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic RESET_HALT = 1'b1;
   localparam int PRESCALE_WIDTH = 6;
endpackage

// File: verif/tmrtb_timebase_asserts.sv
// Purpose: Port checks for the timer timebase
// Assumes: clk_en held high
// Notes: count_value lags the counter by one cycle
`timescale 1ns/1ps
`default_nettype none
module tmrtb_timebase_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic break_active,
   input wire logic stop_mode,
   input wire logic wrap_irq,
   input wire logic [15:0] count_value,
   input wire logic wrap_event
);
   // *****
   // Checks
   // *****
   logic wr_done;
   wire pwr = psel && penable && pready && pwrite && pstrb[0];
   wire st_wr = pwr && paddr == tmrtb_pkg::ADDR_STATUS_CONTROL;
   wire rst_wr = st_wr && pwdata[tmrtb_pkg::BIT_COUNTER_RESET];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_done <= 1'b0;
      end else if (pwr) begin
         wr_done <= 1'b1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   halt_from_reset_a: assert property (!wr_done |-> count_value == 16'h0000)
      else $error("count moved before any write");
   break_hold_a: assert property (
      break_active && $past(break_active) && $past(break_active, 2) |-> $stable(count_value))
      else $error("count moved in break");
   stop_hold_a: assert property (
      stop_mode && $past(stop_mode) && $past(stop_mode, 2) |-> $stable(count_value))
      else $error("count moved in stop mode");
   step_one_a: assert property (
      count_value != $past(count_value) |->
      count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
      else $error("count step not one");
   wrap_zero_a: assert property (wrap_event |-> ##[0:2] count_value == 16'h0000)
      else $error("no restart at zero after wrap");
   irq_clear_a: assert property ($fell(wrap_irq) |-> pwr || $past(pwr) || $past(pwr, 2))
      else $error("interrupt fell without a write");
   counter_reset_a: assert property (rst_wr |-> ##[1:3] count_value == 16'h0000)
      else $error("counter reset bit ignored");
   halt_at_zero_a: assert property (
      rst_wr && pwdata[tmrtb_pkg::BIT_COUNTER_HALT] |-> ##3 (count_value == 16'h0000) [*4])
      else $error("halted counter not at zero");
endmodule
bind tmrtb_timebase tmrtb_timebase_asserts tmrtb_timebase_asserts_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .break_active(break_active),
   .stop_mode(stop_mode), .wrap_irq(wrap_irq), .count_value(count_value),
   .wrap_event(wrap_event));
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the timer timebase
// Assumes: APB slave answers with pready
// Notes: Slow divider keeps clear sequences clear of wraps
`timescale 1ns/1ps
`default_nettype none
module tb;
   // *****
   // Bench
   // *****
   localparam logic [11:0] a_sc = tmrtb_pkg::ADDR_STATUS_CONTROL;
   localparam logic [11:0] a_ch = tmrtb_pkg::ADDR_COUNT_HIGH;
   localparam logic [11:0] a_cl = tmrtb_pkg::ADDR_COUNT_LOW;
   localparam logic [11:0] a_lh = tmrtb_pkg::ADDR_LIMIT_HIGH;
   localparam logic [11:0] a_ll = tmrtb_pkg::ADDR_LIMIT_LOW;
   localparam logic [11:0] a_bc = tmrtb_pkg::ADDR_BREAK_CONTROL;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic brk = 1'b0, stp = 1'b0, ext = 1'b0, ce = 1'b1, err;
   logic [31:0] prdata;
   logic pready, pslverr, wrap_irq, wrap_event;
   logic [15:0] count_value, n;
   logic [7:0] v, w, r;
   int error_cnt = 0, checks = 0;
   always #2 pclk = ~pclk;
   tmrtb_timebase tmrtb_timebase_i (.pclk(pclk), .presetn(presetn), .clk_en(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .break_active(brk), .stop_mode(stp), .external_count_clock(ext),
      .wrap_irq(wrap_irq), .count_value(count_value), .wrap_event(wrap_event));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic wd, input logic [7:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wd;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00);
      chk(r, e);
   endtask
   task automatic wait_ev;
      do @(posedge pclk); while (wrap_event !== 1'b1);
   endtask
   task automatic t_reset;
      rdc(a_sc, 8'h20);
      rdc(a_lh, 8'hFF);
      rdc(a_ll, 8'hFF);
      rdc(a_ch, 8'h00);
      xfer(12'h018, 1'b0, 8'h00);
      chk(err, 1'b1);
   endtask
   task automatic t_divide;
      // Halt and reset before a new limit
      xfer(a_sc, 1'b1, 8'h30);
      xfer(a_lh, 1'b1, 8'h00);
      xfer(a_ll, 1'b1, 8'h07);
      rdc(a_lh, 8'h00);
      xfer(a_lh, 1'b1, 8'h00);
      xfer(a_sc, 1'b1, 8'h00);
      n = 16'h0000;
      repeat (40) begin
         @(posedge pclk);
         if (wrap_event === 1'b1) n++;
      end
      chk(n, 16'h0000);
      xfer(a_ll, 1'b1, 8'h07);
      for (int d = 0; d < 7; d++) begin
         xfer(a_sc, 1'b1, 8'(d));
         wait_ev;
         n = 16'h0000;
         do begin @(posedge pclk); n++; end while (wrap_event !== 1'b1);
         chk(n, 16'h0008 << d);
      end
   endtask
   task automatic t_flag;
      xfer(a_sc, 1'b1, 8'h46);
      wait_ev;
      @(posedge pclk);
      @(posedge pclk);
      chk(wrap_irq, 1'b1);
      rdc(a_sc, 8'hC6);
      xfer(a_sc, 1'b1, 8'h46);
      rdc(a_sc, 8'h46);
      xfer(a_sc, 1'b1, 8'hC6);
      rdc(a_sc, 8'h46);
      chk(wrap_irq, 1'b0);
      wait_ev;
      rdc(a_sc, 8'hC6);
      wait_ev;
      xfer(a_sc, 1'b1, 8'h46);
      rdc(a_sc, 8'hC6);
   endtask
   task automatic t_break;
      wait_ev;
      rdc(a_sc, 8'hC6);
      brk <= 1'b1;
      xfer(a_sc, 1'b1, 8'h46);
      rdc(a_sc, 8'hC6);
      xfer(a_ch, 1'b0, 8'h00);
      xfer(a_cl, 1'b0, 8'h00);
      v = r;
      repeat (200) @(posedge pclk);
      xfer(a_ch, 1'b0, 8'h00);
      rdc(a_cl, v);
      xfer(a_ch, 1'b0, 8'h00);
      brk <= 1'b0;
      repeat (150) @(posedge pclk);
      xfer(a_ch, 1'b0, 8'h00);
      rdc(a_cl, v);
      xfer(a_sc, 1'b1, 8'h46);
      rdc(a_sc, 8'h46);
      wait_ev;
      brk <= 1'b1;
      xfer(a_bc, 1'b1, 8'h01);
      rdc(a_sc, 8'hC6);
      xfer(a_sc, 1'b1, 8'h46);
      brk <= 1'b0;
      rdc(a_sc, 8'h46);
      xfer(a_bc, 1'b1, 8'h00);
      // Halt bit stays clear into low power
      stp <= 1'b1;
      xfer(a_cl, 1'b0, 8'h00);
      w = r;
      repeat (150) @(posedge pclk);
      rdc(a_cl, w);
      stp <= 1'b0;
   endtask
   task automatic t_ext;
      xfer(a_sc, 1'b1, 8'h17);
      repeat (5) begin
         ext <= 1'b1;
         repeat (4) @(posedge pclk);
         ext <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      rdc(a_ch, 8'h00);
      rdc(a_cl, 8'h05);
      chk(count_value, 16'h0005);
      ce <= 1'b0;
      ext <= 1'b1;
      repeat (8) @(posedge pclk);
      ext <= 1'b0;
      repeat (4) @(posedge pclk);
      ce <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(count_value, 16'h0005);
      rdc(a_ll, 8'h07);
      xfer(a_sc, 1'b1, 8'h37);
      rdc(a_cl, 8'h00);
      repeat (8) @(posedge pclk);
      chk(count_value, 16'h0000);
   endtask
   task automatic test_done;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_divide;
      t_flag;
      t_break;
      t_ext;
      test_done;
   end
endmodule
`default_nettype wire
